// [core/miw_core.sv]
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Hardware interrupts are delivered only while the global enable is set; instructions set/clear it.
// - Software trap vectors to 0x001 regardless of global enable and clears it.
// - Return-from-interrupt sets global enable and resumes the interrupted sequence.
// - Each event sets its flag; it stays set until firmware writes 0.
// - A flag reads back only while its own enable bit is set.
// - Pending enabled flag with global enable vectors to 0x008 and clears global enable.
// - Enable instruction inside a service routine re-arms nesting.
// - Timer0 overflow sets timer0 flag; serviced with its enable and global enable.
// - Timer1 underflow sets timer1 flag; serviced with its enable and global enable.
// - Timer4 underflow sets timer4 flag; serviced with its enable and global enable.
// - Watchdog expiry in interrupt mode sets flag bit 6; request needs enable 6.
// - Every watchdog timeout clears timeout status bit 4.
// - Configuration picks reset or interrupt on expiry, and enables the watchdog.
// - Power control bit 7 starts or stops the configured watchdog.
// - Base timeout is one of four periods, 3.5 ms up to 250 ms.
// - Prescaler divides 1:1..1:128 in reset mode, 1:2..1:256 in interrupt mode.
// - Clear-watchdog clears counter and prescaler and sets timeout status.
// - Level change on selected input pins sets pin-change flag.
// - External edge select on a shared pin disables its level-change detection.
// - External 0 chosen edge on pin 4 of port A sets its flag.
// - Twelve hardware sources, each with flag and enable, plus one software trap with neither.
// - External 1 chosen edge on pin 3 of port A sets its flag.
// - External 2 chosen edge on pin 5 of port A sets its flag.
// - Comparator change raises flag; oscillator control read re-arms change detection.
// - Converter end-of-conversion sets converter flag.
module miw_core
    import miw_pkg::*;
#(
    parameter int unsigned WDT_CYC0 = WDT_P0_CYC,    // Base period 0 in cycles
    parameter int unsigned WDT_CYC1 = WDT_P1_CYC,    // Base period 1 in cycles
    parameter int unsigned WDT_CYC2 = WDT_P2_CYC,    // Base period 2 in cycles
    parameter int unsigned WDT_CYC3 = WDT_P3_CYC     // Base period 3 in cycles
) (
    input  wire logic        clk,               // Core clock
    input  wire logic        resetn,            // Synchronous reset, low active
    input  wire logic [4:0]  address,           // Avalon byte address
    input  wire logic        read,              // Avalon read
    input  wire logic        write,             // Avalon write
    input  wire logic [31:0] writedata,         // Avalon write data
    input  wire logic [3:0]  byteenable,        // Avalon byte enables
    output logic [31:0]      readdata,          // Avalon read data
    output logic             waitrequest,       // Avalon wait
    input  wire miw_instr_t  instr,             // Instruction strobes
    input  wire miw_evt_t    evt,               // Peripheral events
    input  wire logic [15:0] pin_in,            // Port B high byte, port A low byte
    input  wire logic [15:0] pin_is_input,      // Pin direction, 1 = input
    input  wire logic        cmp_out,           // Comparator output level
    output logic             vector_req,        // Fetch redirect pulse
    output logic [10:0]      vector_addr,       // Fetch redirect address
    output logic             global_irq_enable, // Global enable state
    output logic             irq_pending,       // Enabled flag pending
    output logic             watchdog_reset     // Watchdog reset pulse
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Watchdog base period for a period select
    function automatic logic [24:0] base_last(input logic [1:0] sel);
        case (sel)
            2'h0:    base_last = 25'(WDT_CYC0 - 1);
            2'h1:    base_last = 25'(WDT_CYC1 - 1);
            2'h2:    base_last = 25'(WDT_CYC2 - 1);
            default: base_last = 25'(WDT_CYC3 - 1);
        endcase
    endfunction : base_last

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] be);
        merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // ****************************************************************
    // State
    // ****************************************************************
    logic [11:0] irq_flag_reg;
    logic [11:0] irq_enable_reg;
    logic        watchdog_run;
    logic        timeout_status_n;
    logic [11:0] config_reg;
    logic [15:0] wake_reg;
    logic [15:0] pin_s1, pin_s2, pin_s3, pin_stable;
    logic        cmp_s1, cmp_s2, cmp_s3, cmp_stable;
    logic        cmp_ref;
    logic        cmp_armed;
    logic [24:0] wdt_cnt;
    logic [7:0]  ps_cnt;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire        wr_acc   = write & ~waitrequest;
    wire        rd_acc   = read & ~waitrequest;
    wire        wr_flag  = wr_acc & (address == ADDR_FLAG);
    wire        wr_en    = wr_acc & (address == ADDR_ENABLE);
    wire        wr_power = wr_acc & (address == ADDR_POWER) & byteenable[0];
    wire        wr_cfg   = wr_acc & (address == ADDR_CONFIG);
    wire        wr_wake  = wr_acc & (address == ADDR_WAKE);
    wire        rd_osc   = rd_acc & (address == ADDR_OSC);
    wire [15:0] flag_wr  = merge16({4'h0, irq_flag_reg}, writedata, byteenable);
    wire [15:0] en_wr    = merge16({4'h0, irq_enable_reg}, writedata, byteenable);
    wire [15:0] cfg_wr   = merge16({4'h0, config_reg}, writedata, byteenable);
    wire [11:0] flag_vis = irq_flag_reg & irq_enable_reg;

    // Read mux, unmapped addresses read zero
    logic [31:0] next_readdata;
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (address)
            ADDR_FLAG:   next_readdata = {20'h0_0000, flag_vis};
            ADDR_ENABLE: next_readdata = {20'h0_0000, irq_enable_reg};
            ADDR_POWER:  next_readdata = {24'h00_0000, watchdog_run, 7'h00};
            ADDR_STATUS: next_readdata = {27'h000_0000, timeout_status_n, 4'h0};
            ADDR_CONFIG: next_readdata = {20'h0_0000, config_reg};
            ADDR_WAKE:   next_readdata = {16'h0000, wake_reg};
            ADDR_OSC:    next_readdata = {25'h000_0000, cmp_stable, 6'h00};
            default:     next_readdata = 32'h0000_0000;
        endcase
    end

    // Wait one cycle on every request, then answer
    wire next_waitrequest = ~((read | write) & waitrequest);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            waitrequest <= next_waitrequest;
            readdata    <= (read & waitrequest) ? next_readdata : readdata;
        end
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    // Configuration, enables, wake selects and run bit
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_enable_reg <= 12'h000;
            config_reg     <= RST_CONFIG;
            wake_reg       <= 16'h0000;
            watchdog_run   <= 1'b0;
        end else begin
            if (wr_en)   irq_enable_reg <= en_wr[11:0];
            if (wr_cfg)  config_reg     <= cfg_wr[11:0];
            if (wr_wake) wake_reg       <= merge16(wake_reg, writedata, byteenable);
            if (wr_power) watchdog_run  <= writedata[POWER_RUN_BIT];
        end
    end

    wire       cfg_wdt_en  = config_reg[CFG_WDT_EN_BIT];
    wire       cfg_wdt_irq = config_reg[CFG_WDT_IRQ_BIT];
    wire [1:0] cfg_period  = config_reg[CFG_PERIOD_LSB +: 2];
    wire       prescaler_to_watchdog = config_reg[CFG_PS_WDT_BIT];
    wire [2:0] prescaler_divide_sel  = config_reg[CFG_PS_SEL_LSB +: 3];
    wire       ext0_select       = config_reg[CFG_EXT0_BIT];
    wire       ext1_select       = config_reg[CFG_EXT1_BIT];
    wire       ext2_select       = config_reg[CFG_EXT2_BIT];
    wire       edge_polarity_sel = config_reg[CFG_EDGE_BIT];

    // ****************************************************************
    // Pin and comparator synchronisers
    // ****************************************************************
    // Three stages; a level counts when stages two and three agree
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_s1     <= 16'h0000;
            pin_s2     <= 16'h0000;
            pin_s3     <= 16'h0000;
            pin_stable <= 16'h0000;
            cmp_s1     <= 1'b0;
            cmp_s2     <= 1'b0;
            cmp_s3     <= 1'b0;
            cmp_stable <= 1'b0;
        end else begin
            pin_s1     <= pin_in;
            pin_s2     <= pin_s1;
            pin_s3     <= pin_s2;
            pin_stable <= (pin_s2 & pin_s3) | (pin_stable & (pin_s2 | pin_s3));
            cmp_s1     <= cmp_out;
            cmp_s2     <= cmp_s1;
            cmp_s3     <= cmp_s2;
            cmp_stable <= (cmp_s2 == cmp_s3) ? cmp_s2 : cmp_stable;
        end
    end

    // ****************************************************************
    // Event detection
    // ****************************************************************
    wire [15:0] next_pin  = (pin_s2 & pin_s3) | (pin_stable & (pin_s2 | pin_s3));
    wire [15:0] pin_chg   = next_pin ^ pin_stable;
    wire [15:0] ext_block = {10'h000, ext2_select, ext0_select, ext1_select, 3'h0};
    wire        pchg_evt  = |(pin_chg & pin_is_input & wake_reg & ~ext_block);
    wire [2:0]  ext_rise  = {next_pin[PIN_EXT2], next_pin[PIN_EXT1], next_pin[PIN_EXT0]}
                          & ~{pin_stable[PIN_EXT2], pin_stable[PIN_EXT1], pin_stable[PIN_EXT0]};
    wire [2:0]  ext_fall  = ~{next_pin[PIN_EXT2], next_pin[PIN_EXT1], next_pin[PIN_EXT0]}
                          & {pin_stable[PIN_EXT2], pin_stable[PIN_EXT1], pin_stable[PIN_EXT0]};
    wire [2:0]  ext_edge  = edge_polarity_sel ? ext_rise : ext_fall;
    wire        ext0_evt  = ext0_select & ext_edge[0];
    wire        ext1_evt  = ext1_select & ext_edge[1];
    wire        ext2_evt  = ext2_select & ext_edge[2];
    wire        cmp_evt   = cmp_armed & (cmp_stable != cmp_ref);

    // Comparator difference is held until the oscillator register is read
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmp_ref   <= 1'b0;
            cmp_armed <= 1'b0;
        end else if (rd_osc) begin
            cmp_ref   <= cmp_stable;
            cmp_armed <= 1'b1;
        end else if (cmp_evt) begin
            cmp_armed <= 1'b0;
        end
    end

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    // Prescaler divide: 1<<sel in reset mode, 2<<sel in interrupt mode; last count is one less
    wire [8:0]  ps_div    = cfg_wdt_irq ? (9'h002 << prescaler_divide_sel)
                                        : (9'h001 << prescaler_divide_sel);
    wire [7:0]  ps_last   = prescaler_to_watchdog ? 8'(ps_div - 9'h001) : 8'h00;
    wire        wdt_on    = cfg_wdt_en & watchdog_run;
    wire        wdt_clr   = instr.clear_watchdog_instr;
    wire        base_tick = wdt_on & (wdt_cnt == base_last(cfg_period));
    wire        wdt_tmo   = base_tick & (ps_cnt == ps_last) & ~wdt_clr;

    // Base counter and prescaler, both cleared by the clear instruction
    always_ff @(posedge clk) begin
        if (!resetn || wdt_clr || !wdt_on) begin
            wdt_cnt <= 25'h000_0000;
            ps_cnt  <= 8'h00;
        end else if (base_tick) begin
            wdt_cnt <= 25'h000_0000;
            ps_cnt  <= (ps_cnt == ps_last) ? 8'h00 : 8'(ps_cnt + 8'h01);
        end else begin
            wdt_cnt <= 25'(wdt_cnt + 25'h000_0001);
        end
    end

    // Timeout status and reset pulse
    always_ff @(posedge clk) begin
        if (!resetn) begin
            timeout_status_n <= 1'b1;
            watchdog_reset   <= 1'b0;
        end else begin
            if (wdt_tmo)      timeout_status_n <= 1'b0;
            else if (wdt_clr) timeout_status_n <= 1'b1;
            watchdog_reset <= wdt_tmo & ~cfg_wdt_irq;
        end
    end

    // ****************************************************************
    // Interrupt flags
    // ****************************************************************
    logic [11:0] set_vec;
    always_comb begin
        set_vec             = 12'h000;
        set_vec[SRC_TIMER0] = evt.timer0_ovf;
        set_vec[SRC_TIMER1] = evt.timer1_unf;
        set_vec[SRC_TIMER4] = evt.timer4_unf;
        set_vec[SRC_PCHG]   = pchg_evt;
        set_vec[SRC_EXT0]   = ext0_evt;
        set_vec[SRC_EXT1]   = ext1_evt;
        set_vec[SRC_WDT]    = wdt_tmo & cfg_wdt_irq;
        set_vec[SRC_EXT2]   = ext2_evt;
        set_vec[SRC_LVD]    = evt.lvd_evt;
        set_vec[SRC_CMP]    = cmp_evt;
        set_vec[SRC_ADC]    = evt.adc_eoc;
        set_vec[SRC_SIM]    = evt.sim_evt;
    end

    // Writes of 0 clear, writes of 1 keep; a new event wins over the clear
    wire [11:0] next_flags = (wr_flag ? (irq_flag_reg & flag_wr[11:0]) : irq_flag_reg)
                           | set_vec;

    always_ff @(posedge clk) begin
        if (!resetn) irq_flag_reg <= RST_FLAGS;
        else         irq_flag_reg <= next_flags;
    end

    // ****************************************************************
    // Global enable and vectoring
    // ****************************************************************
    wire hw_req  = |flag_vis;
    wire hw_take = hw_req & global_irq_enable & ~instr.sw_trap_instr;

    // Trap first, then a hardware take, then the enable instructions
    logic next_global_irq_enable;
    always_comb begin
        next_global_irq_enable = global_irq_enable;
        if (instr.sw_trap_instr)               next_global_irq_enable = 1'b0;
        else if (hw_take)                      next_global_irq_enable = 1'b0;
        else if (instr.enable_irq_instr)       next_global_irq_enable = 1'b1;
        else if (instr.return_from_isr_instr)  next_global_irq_enable = 1'b1;
        else if (instr.disable_irq_instr)      next_global_irq_enable = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            global_irq_enable <= 1'b0;
            vector_req        <= 1'b0;
            vector_addr       <= 11'h000;
            irq_pending       <= 1'b0;
        end else begin
            global_irq_enable <= next_global_irq_enable;
            vector_req        <= instr.sw_trap_instr | hw_take;
            vector_addr       <= instr.sw_trap_instr ? VEC_SW :
                                 (hw_take ? VEC_HW : vector_addr);
            irq_pending       <= hw_req;
        end
    end

endmodule : miw_core

`default_nettype wire

// [common/miw_pkg.sv]
package miw_pkg;

    // ****************************************************************
    // Register map (byte addresses on the Avalon-MM slave)
    // ****************************************************************
    localparam logic [4:0] ADDR_FLAG   = 5'h00;
    localparam logic [4:0] ADDR_ENABLE = 5'h04;
    localparam logic [4:0] ADDR_POWER  = 5'h08;
    localparam logic [4:0] ADDR_STATUS = 5'h0C;
    localparam logic [4:0] ADDR_CONFIG = 5'h10;
    localparam logic [4:0] ADDR_WAKE   = 5'h14;
    localparam logic [4:0] ADDR_OSC    = 5'h18;

    // ****************************************************************
    // Source positions in the flag and enable registers
    // ****************************************************************
    localparam int NUM_SRC    = 12;
    localparam int SRC_TIMER0 = 0;
    localparam int SRC_TIMER1 = 1;
    localparam int SRC_TIMER4 = 2;
    localparam int SRC_PCHG   = 3;
    localparam int SRC_EXT0   = 4;
    localparam int SRC_EXT1   = 5;
    localparam int SRC_WDT    = 6;
    localparam int SRC_EXT2   = 7;
    localparam int SRC_LVD    = 8;
    localparam int SRC_CMP    = 9;
    localparam int SRC_ADC    = 10;
    localparam int SRC_SIM    = 11;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int POWER_RUN_BIT      = 7;
    localparam int STATUS_TMO_BIT     = 4;
    localparam int OSC_CMP_BIT        = 6;
    localparam int CFG_WDT_EN_BIT     = 0;
    localparam int CFG_WDT_IRQ_BIT    = 1;
    localparam int CFG_PERIOD_LSB     = 2;
    localparam int CFG_PS_WDT_BIT     = 4;
    localparam int CFG_PS_SEL_LSB     = 5;
    localparam int CFG_EXT0_BIT       = 8;
    localparam int CFG_EXT1_BIT       = 9;
    localparam int CFG_EXT2_BIT       = 10;
    localparam int CFG_EDGE_BIT       = 11;
    localparam int PIN_EXT1           = 3;
    localparam int PIN_EXT0           = 4;
    localparam int PIN_EXT2           = 5;
    localparam logic [11:0] RST_CONFIG = 12'h000;
    localparam logic [11:0] RST_FLAGS  = 12'h000;

    // ****************************************************************
    // Vectors and watchdog timing
    // ****************************************************************
    localparam logic [10:0] VEC_SW = 11'h001;
    localparam logic [10:0] VEC_HW = 11'h008;
    localparam int CLK_MHZ         = 100;
    localparam int WDT_P0_US       = 3500;
    localparam int WDT_P1_US       = 15000;
    localparam int WDT_P2_US       = 60000;
    localparam int WDT_P3_US       = 250000;
    localparam int WDT_P0_CYC      = WDT_P0_US * CLK_MHZ;
    localparam int WDT_P1_CYC      = WDT_P1_US * CLK_MHZ;
    localparam int WDT_P2_CYC      = WDT_P2_US * CLK_MHZ;
    localparam int WDT_P3_CYC      = WDT_P3_US * CLK_MHZ;

    // Instruction strobes from the core, one cycle each
    typedef struct packed {
        logic enable_irq_instr;
        logic disable_irq_instr;
        logic return_from_isr_instr;
        logic sw_trap_instr;
        logic clear_watchdog_instr;
    } miw_instr_t;

    // Peripheral event pulses on the core clock
    typedef struct packed {
        logic timer0_ovf;
        logic timer1_unf;
        logic timer4_unf;
        logic lvd_evt;
        logic adc_eoc;
        logic sim_evt;
    } miw_evt_t;

endpackage : miw_pkg

// [sim/miw_core_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Port checker for the interrupt block
// ****************************************************************
module miw_core_monitor
    import miw_pkg::*;
(
    input wire logic        clk,               // Core clock
    input wire logic        resetn,            // Reset, low active
    input wire logic        read,              // Bus read
    input wire logic        write,             // Bus write
    input wire logic        waitrequest,       // Bus wait
    input wire miw_instr_t  instr,             // Core strobes
    input wire logic        vector_req,        // Fetch redirect
    input wire logic [10:0] vector_addr,       // Redirect target
    input wire logic        global_irq_enable, // Global enable
    input wire logic        irq_pending,       // Enabled flag pending
    input wire logic        watchdog_reset     // Watchdog reset pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Redirect steps
    sequence s_hw_take; vector_req && vector_addr == VEC_HW && !global_irq_enable; endsequence
    sequence s_sw_take; vector_req && vector_addr == VEC_SW && !global_irq_enable; endsequence
    property p_trap; instr.sw_trap_instr |=> s_sw_take; endproperty
    a_trap: assert property (p_trap) else $error("trap redirect wrong");
    property p_hw; irq_pending && global_irq_enable && !instr.sw_trap_instr |=> s_hw_take; endproperty
    a_hw: assert property (p_hw) else $error("hardware redirect wrong");
    property p_gate; !global_irq_enable && !instr.sw_trap_instr |=> !vector_req; endproperty
    a_gate: assert property (p_gate) else $error("redirect without enable");
    property p_en_instr; instr.enable_irq_instr && !instr.sw_trap_instr && !instr.disable_irq_instr
        && !global_irq_enable |=> global_irq_enable; endproperty
    a_en_instr: assert property (p_en_instr) else $error("enable not set");
    property p_dis_instr; instr.disable_irq_instr && !instr.enable_irq_instr && !instr.return_from_isr_instr
        |=> !global_irq_enable; endproperty
    a_dis_instr: assert property (p_dis_instr) else $error("enable not cleared");
    property p_reti; instr.return_from_isr_instr && !instr.sw_trap_instr && !instr.disable_irq_instr
        && !global_irq_enable |=> global_irq_enable; endproperty
    a_reti: assert property (p_reti) else $error("return left enable low");
    property p_ack; (read || write) && waitrequest |=> !waitrequest ##1 waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("bus answer timing");
    property p_wdr; watchdog_reset |=> !watchdog_reset [*8]; endproperty
    a_wdr: assert property (p_wdr) else $error("watchdog reset not a pulse");
endmodule : miw_core_monitor
`default_nettype wire

// [sim/miw_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Core side: replays instruction strobes, counts redirects
// ****************************************************************
module miw_core_model
    import miw_pkg::*;
(
    input  wire logic       clk,        // Core clock
    input  wire logic       vector_req, // Redirect pulse
    input  wire miw_instr_t cmd,        // Strobe asked by the bench
    output miw_instr_t      instr,      // Strobes to the block
    output int              takes       // Redirects seen
);
    // Bench strobes pass to the block unchanged, one cycle late
    always_ff @(posedge clk) begin
        instr <= cmd;
        takes <= takes + int'(vector_req);
    end
endmodule : miw_core_model
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import miw_pkg::*;
    localparam logic [4:0] I_ON = 5'h10, I_OFF = 5'h08, I_RET = 5'h04, I_TRAP = 5'h02, I_CLRW = 5'h01;
    logic clk = 0, resetn = 0, read = 0, write = 0, cmp_out = 0;
    logic waitrequest, vector_req, global_irq_enable, irq_pending, watchdog_reset;
    logic [4:0] address = '0;
    logic [31:0] writedata = '0, readdata, rd;
    logic [3:0] byteenable = 4'hF;
    logic [10:0] vector_addr;
    logic [15:0] pin_in = '0, pin_is_input = 16'hFFFF;
    miw_instr_t cmd = '0, instr;
    miw_evt_t evt = '0;
    int n_errors = 0, num_checks = 0, seed = 37, takes, en, k, t;
    miw_core #(.WDT_CYC0(20), .WDT_CYC1(30), .WDT_CYC2(40), .WDT_CYC3(50)) dut (.*);
    miw_core_model core (.*);
    // Clock and watchdog
    initial forever #5 clk = ~clk;
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
    task automatic chk(input logic [31:0] g, e, input string m);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask : chk
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int w;
        w = 0;
        address <= a; writedata <= d; read <= !wr; write <= wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
            w++;
        end
        rd = readdata;
        read <= 0; write <= 0;
        @(posedge clk);
        chk(w < 50, 1, "bus hang");
    endtask : bus
    task automatic ins(input logic [4:0] c);
        cmd <= c;
        @(posedge clk);
        cmd <= '0;
        repeat (5) @(posedge clk);
    endtask : ins
    task automatic fire(input logic [5:0] e);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        repeat (5) @(posedge clk);
    endtask : fire
    task automatic wdwait;
        for (t = 0; t < 60 && watchdog_reset !== 1'b1; t++) @(posedge clk);
    endtask : wdwait
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1;
        bus(0, ADDR_CONFIG, 0); chk(rd, 0, "config reset");
        bus(0, ADDR_STATUS, 0); chk(rd[4], 1, "status reset");
        bus(0, 5'h1C, 0); chk(rd, 0, "unmapped read");
        $display("reset test done");
        // Random enables, all six peripheral event pulses, masked read-back
        for (k = 0; k < 4; k++) begin
            en = $random(seed) & 32'hFFF;
            bus(1, ADDR_FLAG, 0);
            bus(1, ADDR_ENABLE, en);
            fire(6'h3F);
            bus(0, ADDR_FLAG, 0); chk(rd, en & 32'hD07, "masked flags");
        end
        bus(1, ADDR_ENABLE, 32'hFFF);
        bus(0, ADDR_FLAG, 0); chk(rd, 32'hD07, "flags held");
        chk(irq_pending, 1, "pending");
        $display("flag test done");
        // Many pending: one redirect, flags kept; then trap and return
        ins(I_ON); chk(takes, 1, "single take");
        chk(vector_addr, VEC_HW, "hw vector");
        chk(global_irq_enable, 0, "enable after take");
        bus(0, ADDR_FLAG, 0); chk(rd, 32'hD07, "flags after take");
        ins(I_TRAP); chk(takes, 2, "trap take");
        chk(vector_addr, VEC_SW, "sw vector");
        bus(1, ADDR_FLAG, 0);
        ins(I_RET); chk(global_irq_enable, 1, "return enable");
        chk(irq_pending, 0, "pending cleared");
        fire(6'h20); chk(takes, 3, "timer0 take");
        bus(1, ADDR_FLAG, 0);
        ins(I_ON); chk(global_irq_enable, 1, "nest enable");
        ins(I_OFF); chk(global_irq_enable, 0, "disable");
        fire(6'h20); chk(takes, 3, "no take when off");
        $display("vector test done");
        // Edge pin and level change pin
        bus(1, ADDR_FLAG, 0);
        bus(1, ADDR_CONFIG, 32'h900);
        bus(1, ADDR_WAKE, 32'h11);
        pin_in <= 16'h0010;
        repeat (8) @(posedge clk);
        bus(0, ADDR_FLAG, 0); chk(rd, 32'h10, "edge pin only");
        pin_in <= 16'h0011;
        repeat (8) @(posedge clk);
        bus(0, ADDR_FLAG, 0); chk(rd, 32'h18, "level change");
        // Comparator change after an arming read, none without one
        bus(1, ADDR_FLAG, 0);
        bus(0, ADDR_OSC, 0);
        cmp_out <= 1;
        repeat (8) @(posedge clk);
        bus(0, ADDR_FLAG, 0); chk(rd, 32'h200, "comparator change");
        bus(1, ADDR_FLAG, 0);
        cmp_out <= 0;
        repeat (8) @(posedge clk);
        bus(0, ADDR_FLAG, 0); chk(rd, 0, "no change until read");
        $display("pin test done");
        // Watchdog in interrupt mode, clear, reset mode, stop
        bus(1, ADDR_FLAG, 0);
        bus(1, ADDR_CONFIG, 32'h3);
        bus(1, ADDR_POWER, 32'h80);
        repeat (30) @(posedge clk);
        bus(0, ADDR_FLAG, 0); chk(rd[6], 1, "watchdog flag");
        bus(0, ADDR_STATUS, 0); chk(rd[4], 0, "timeout status");
        ins(I_CLRW);
        bus(0, ADDR_STATUS, 0); chk(rd[4], 1, "status after clear");
        bus(1, ADDR_CONFIG, 32'h1);
        wdwait(); chk(t < 60, 1, "watchdog reset");
        bus(1, ADDR_POWER, 0);
        wdwait(); chk(t, 60, "watchdog stopped");
        $display("watchdog test done");
        wrap_up();
    end
endmodule : testbench
bind miw_core miw_core_monitor u_mon (.*);
`default_nettype wire
